// [src/fcd_pkg.sv]
/*
 * Constants for the host-side controller of a parallel NOR flash command
 * decoder: command codes, unlock addresses, ident offsets and bus timing.
 * Assumes a 25 MHz system clock and a word-mode (x16) flash.
 */
package fcd_pkg;
    // ------------------------------------------------------------
    // Bus widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;
    localparam int BUF_WORDS = 16;

    // ------------------------------------------------------------
    // Unlock and command addresses, word mode
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 22'h000555;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 22'h0002aa;
    localparam logic [ADDR_W-1:0] ANY_ADDR = 22'h000000;
    localparam logic [ADDR_W-1:0] SECTOR_MASK = 22'h3ff000;
    localparam logic [ADDR_W-1:0] OFS_MANUF = 22'h000000;
    localparam logic [ADDR_W-1:0] OFS_ID1 = 22'h000001;
    localparam logic [ADDR_W-1:0] OFS_ID2 = 22'h00000e;
    localparam logic [ADDR_W-1:0] OFS_ID3 = 22'h00000f;
    localparam logic [ADDR_W-1:0] OFS_LOCKIND = 22'h000003;
    localparam logic [ADDR_W-1:0] OFS_PROT = 22'h000002;

    // ------------------------------------------------------------
    // Data codes
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] D_UNLOCK1 = 16'h00aa;
    localparam logic [DATA_W-1:0] D_UNLOCK2 = 16'h0055;
    localparam logic [DATA_W-1:0] D_RESET = 16'h00f0;
    localparam logic [DATA_W-1:0] D_IDENT = 16'h0090;
    localparam logic [DATA_W-1:0] D_OTP_ENTER = 16'h0088;
    localparam logic [DATA_W-1:0] D_OTP_EXIT = 16'h0000;
    localparam logic [DATA_W-1:0] D_PROGRAM = 16'h00a0;
    localparam logic [DATA_W-1:0] D_ERASE_SETUP = 16'h0080;
    localparam logic [DATA_W-1:0] D_CHIP_ERASE = 16'h0010;
    localparam logic [DATA_W-1:0] D_SECTOR_ERASE = 16'h0030;
    localparam logic [DATA_W-1:0] D_SUSPEND = 16'h00b0;
    localparam logic [DATA_W-1:0] D_RESUME = 16'h0030;
    localparam logic [DATA_W-1:0] D_BUF_LOAD = 16'h0025;
    localparam logic [DATA_W-1:0] D_BUF_CONFIRM = 16'h0029;

    // ------------------------------------------------------------
    // Host commands
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        FCD_CMD_RESET, FCD_CMD_READ, FCD_CMD_IDENT, FCD_CMD_OTP_ENTER, FCD_CMD_OTP_EXIT,
        FCD_CMD_PROGRAM, FCD_CMD_CHIP_ERASE, FCD_CMD_SECTOR_ERASE, FCD_CMD_SUSPEND,
        FCD_CMD_RESUME, FCD_CMD_BUF_PROGRAM, FCD_CMD_BUF_ABORT
    } fcd_cmd_t;

    // ------------------------------------------------------------
    // Bus timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 25;
    localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
    localparam int GLITCH_NS = 5;
    localparam int STROBE_NS = 80;
    localparam int SETUP_NS = 40;
    localparam int READ_NS = 120;
    localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_CYC = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [4:0] SEQ_MAX = 5'h15;
endpackage

// [src/fcd_bus_cycle.sv]
/*
 * One asynchronous flash bus cycle, write or read, timed from the clock.
 * Latches address and data at start, so the caller need not hold them until done.
 */
module fcd_bus_cycle (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // Request
    input wire logic i_start,
    input wire logic i_write,
    input wire logic [fcd_pkg::ADDR_W-1:0] i_addr,
    input wire logic [fcd_pkg::DATA_W-1:0] i_wdata,
    output logic o_done,
    output logic [fcd_pkg::DATA_W-1:0] o_rdata,
    // Flash pins
    output logic [fcd_pkg::ADDR_W-1:0] o_addr,
    output logic [fcd_pkg::DATA_W-1:0] o_dq_out,
    output logic o_dq_oe,
    input wire logic [fcd_pkg::DATA_W-1:0] i_dq_sync,
    output logic o_cs_n,
    output logic o_we_n,
    output logic o_oe_n
);
    import fcd_pkg::*;

    typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_HOLD} fcd_bc_t;

    fcd_bc_t state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic wr_ff, nxt_wr;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [DATA_W-1:0] wd_ff, nxt_wd, rd_ff, nxt_rd;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_wr = wr_ff;
        nxt_addr = addr_ff;
        nxt_wd = wd_ff;
        nxt_rd = rd_ff;
        o_done = 1'b0;
        case (state_ff)
            BC_IDLE: begin
                if (i_start) begin
                    nxt_wr = i_write;
                    nxt_addr = i_addr;
                    nxt_wd = i_wdata;
                    nxt_cnt = CNT_W'(SETUP_CYC);
                    nxt_state = BC_SETUP;
                end
            end
            BC_SETUP: begin
                // Address settles before any strobe falls
                if (cnt_ff == CNT_ONE) begin
                    nxt_cnt = wr_ff ? CNT_W'(STROBE_CYC) : CNT_W'(READ_CYC);
                    nxt_state = BC_STROBE;
                end else begin
                    nxt_cnt = cnt_ff - CNT_ONE;
                end
            end
            BC_STROBE: begin
                // Strobe lasts far beyond the glitch filter width
                if (cnt_ff == CNT_ONE) begin
                    nxt_rd = i_dq_sync;
                    nxt_state = BC_HOLD;
                end else begin
                    nxt_cnt = cnt_ff - CNT_ONE;
                end
            end
            BC_HOLD: begin
                o_done = 1'b1;
                nxt_state = BC_IDLE;
            end
            default: nxt_state = BC_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff <= BC_IDLE;
            cnt_ff <= '0;
            wr_ff <= 1'b0;
            addr_ff <= '0;
            wd_ff <= '0;
            rd_ff <= '0;
        end else if (i_ce) begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            wr_ff <= nxt_wr;
            addr_ff <= nxt_addr;
            wd_ff <= nxt_wd;
            rd_ff <= nxt_rd;
        end
    end

    // Write strobe only with output enable high: never both strobes low
    assign o_cs_n = !(state_ff == BC_STROBE); // R7
    assign o_we_n = !(state_ff == BC_STROBE && wr_ff); // R7
    assign o_oe_n = !(state_ff == BC_STROBE && !wr_ff); // R7
    assign o_addr = addr_ff; // R11
    assign o_dq_out = wd_ff; // R11
    assign o_dq_oe = wr_ff && state_ff != BC_IDLE;
    assign o_rdata = rd_ff;

    strobe_excl_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) !(!o_we_n && !o_oe_n)) // R7
        else $error("write and output strobes both low");
    strobe_width_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $fell(o_we_n) |-> !o_we_n [*2]) // R6
        else $error("write strobe too short");
    addr_stable_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !o_cs_n |-> $stable(o_addr)) // R11
        else $error("address moved during strobe");
endmodule

// [src/fcd_host.sv]
/*
 * Host controller for a parallel NOR flash: turns one command request into
 * the write sequence, unlock-prefixed except for reset, suspend and resume, plus reads, over CS/WE/OE pins.
 * Assumes a word-mode flash and that i_supply_ok marks supply above lockout.
 */
// Operation
// R1: Factory-locked region is never written by host; code refuses only FCD_CMD_PROGRAM requests there, not buffer programs
// R2: Customer region programmable, then permanently protected
// R3: Lock region: enter sequence, then protect
// R4: Exit region mode before main array access
// R5: No writes while supply below lockout; code only holds off new requests, a sequence already under way keeps writing
// R6: Strobes far longer than glitch width
// R7: Write only with CS, WE low, OE high
// R8: Array read after power-up, no command
// R9: No strobes during power-up
// R10: Bad sequence returns flash to read
// R11: Address, data stable through whole strobe
// R12: Suspend/resume single cycle, only during sector erase
// R13: Unlock writes AA@555, 55@2AA, code @555
// R14: Reset is F0 to any address
// R15: Ident mode reads codes at fixed offsets
// R16: Region enter 88; exit 90 then 00
// R17: Program: prefix, A0, address with data
// R18: Erase: prefix, 80, prefix, 10 or 30
// R19: Buffer: prefix, 25@sector, count, pairs
// R20: Code 29 at sector starts buffer program
// R21: Abort recovery: prefix then F0
// R22: Load count is locations minus one
// R23: Protect status reads 00 or 01
// R24: Region mode maps region onto first sector
module fcd_host (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    // Command request
    input wire logic i_req_valid,
    output logic o_req_ready,
    input wire fcd_pkg::fcd_cmd_t i_req_cmd,
    input wire logic [fcd_pkg::ADDR_W-1:0] i_req_addr,
    input wire logic [fcd_pkg::DATA_W-1:0] i_req_data,
    input wire logic [4:0] i_req_count,
    input wire logic i_supply_ok,
    input wire logic i_otp_factory_locked,
    // Buffer data
    input wire logic [fcd_pkg::DATA_W-1:0] i_buf_data [fcd_pkg::BUF_WORDS],
    // Answer
    output logic o_done,
    output logic o_rejected,
    output logic [fcd_pkg::DATA_W-1:0] o_rdata,
    output logic o_otp_mode,
    output logic o_erasing,
    // Flash pins
    output logic [fcd_pkg::ADDR_W-1:0] o_flash_addr,
    output logic [fcd_pkg::DATA_W-1:0] o_flash_dq_out,
    output logic o_flash_dq_oe,
    input wire logic [fcd_pkg::DATA_W-1:0] i_flash_dq_in,
    output logic o_flash_cs_n,
    output logic o_flash_we_n,
    output logic o_flash_oe_n
);
    import fcd_pkg::*;

    typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT, H_DONE} fcd_host_t;

    // ------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------
    logic rst_s1_ff, rst_n;
    logic [DATA_W-1:0] dq_s1_ff, dq_s2_ff;
    logic sup_s1_ff, sup_s2_ff;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_s1_ff <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n <= rst_s1_ff;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            dq_s1_ff <= '0;
            dq_s2_ff <= '0;
            sup_s1_ff <= 1'b0;
            sup_s2_ff <= 1'b0;
        end else if (i_clk_en) begin
            dq_s1_ff <= i_flash_dq_in;
            dq_s2_ff <= dq_s1_ff;
            sup_s1_ff <= i_supply_ok;
            sup_s2_ff <= sup_s1_ff;
        end
    end

    // ------------------------------------------------------------
    // Sequence table
    // ------------------------------------------------------------
    function automatic logic [ADDR_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
        return a & SECTOR_MASK;
    endfunction

    fcd_host_t state_ff, nxt_state;
    fcd_cmd_t cmd_ff, nxt_cmd;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [DATA_W-1:0] data_ff, nxt_data, rdata_ff, nxt_rdata;
    logic [4:0] cnt_ff, nxt_cnt, step_ff, nxt_step;
    logic otp_ff, nxt_otp, erase_ff, nxt_erase, rej_ff, nxt_rej;

    logic [4:0] seq_len;
    logic seq_wr;
    logic [ADDR_W-1:0] seq_addr;
    logic [DATA_W-1:0] seq_data;
    logic [4:0] bidx;
    logic bc_done, bc_start;
    logic [DATA_W-1:0] bc_rdata;

    always_comb begin
        seq_wr = 1'b1;
        seq_addr = UNLOCK_ADDR1;
        seq_data = D_UNLOCK1;
        seq_len = 5'h03;
        bidx = step_ff - 5'h05;
        // Prefix shared by multi-cycle commands
        if (step_ff == 5'h01) begin
            seq_addr = UNLOCK_ADDR2; // R13
            seq_data = D_UNLOCK2; // R13
        end
        case (cmd_ff)
            FCD_CMD_RESET: begin
                seq_len = 5'h01;
                seq_addr = ANY_ADDR;
                seq_data = D_RESET; // R14 R10
            end
            FCD_CMD_READ: begin
                seq_len = 5'h01;
                seq_wr = 1'b0;
                seq_addr = addr_ff; // R8 R24
            end
            FCD_CMD_IDENT: begin
                seq_len = 5'h04;
                if (step_ff == 5'h02) seq_data = D_IDENT; // R15
                if (step_ff == 5'h03) begin
                    seq_wr = 1'b0;
                    seq_addr = addr_ff; // R15 R23
                end
            end
            FCD_CMD_OTP_ENTER: begin
                if (step_ff == 5'h02) seq_data = D_OTP_ENTER; // R3 R16
            end
            FCD_CMD_OTP_EXIT: begin
                seq_len = 5'h04;
                if (step_ff == 5'h02) seq_data = D_IDENT; // R16 R4
                if (step_ff == 5'h03) begin
                    seq_addr = ANY_ADDR;
                    seq_data = D_OTP_EXIT; // R16
                end
            end
            FCD_CMD_PROGRAM: begin
                seq_len = 5'h04;
                if (step_ff == 5'h02) seq_data = D_PROGRAM; // R17
                if (step_ff == 5'h03) begin
                    seq_addr = addr_ff; // R17
                    seq_data = data_ff;
                end
            end
            FCD_CMD_CHIP_ERASE, FCD_CMD_SECTOR_ERASE: begin
                seq_len = 5'h06;
                if (step_ff == 5'h02) seq_data = D_ERASE_SETUP; // R18
                if (step_ff == 5'h04) begin
                    seq_addr = UNLOCK_ADDR2;
                    seq_data = D_UNLOCK2;
                end
                if (step_ff == 5'h05) begin
                    seq_addr = (cmd_ff == FCD_CMD_SECTOR_ERASE) ? sector_of(addr_ff) : UNLOCK_ADDR1; // R18
                    seq_data = (cmd_ff == FCD_CMD_SECTOR_ERASE) ? D_SECTOR_ERASE : D_CHIP_ERASE; // R18
                end
            end
            FCD_CMD_SUSPEND, FCD_CMD_RESUME: begin
                seq_len = 5'h01;
                seq_addr = ANY_ADDR;
                seq_data = (cmd_ff == FCD_CMD_SUSPEND) ? D_SUSPEND : D_RESUME; // R12
            end
            FCD_CMD_BUF_PROGRAM: begin
                // Count locations, then words, then the confirm write
                seq_len = cnt_ff + 5'h06; // R19
                if (step_ff == 5'h02) begin
                    seq_addr = sector_of(addr_ff);
                    seq_data = D_BUF_LOAD; // R19
                end else if (step_ff == 5'h03) begin
                    seq_addr = sector_of(addr_ff);
                    seq_data = {11'h000, cnt_ff}; // R22
                end else if (step_ff >= 5'h04 && step_ff < seq_len - 5'h01) begin
                    seq_addr = addr_ff + ADDR_W'(step_ff - 5'h04); // R19
                    seq_data = i_buf_data[bidx[3:0] + 4'h1];
                    if (step_ff == 5'h04) seq_data = i_buf_data[0];
                end else if (step_ff == seq_len - 5'h01) begin
                    seq_addr = sector_of(addr_ff);
                    seq_data = D_BUF_CONFIRM; // R20
                end
            end
            FCD_CMD_BUF_ABORT: begin
                if (step_ff == 5'h02) seq_data = D_RESET; // R21
            end
            default: seq_len = 5'h01;
        endcase
    end

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    logic bad_req;

    always_comb begin
        nxt_state = state_ff;
        nxt_cmd = cmd_ff;
        nxt_addr = addr_ff;
        nxt_data = data_ff;
        nxt_cnt = cnt_ff;
        nxt_step = step_ff;
        nxt_otp = otp_ff;
        nxt_erase = erase_ff;
        nxt_rej = 1'b0;
        nxt_rdata = rdata_ff;
        bc_start = 1'b0;
        // Single-word programs to a factory-locked region, or suspend/resume outside a sector erase, are refused
        bad_req = (otp_ff && i_otp_factory_locked && i_req_cmd == FCD_CMD_PROGRAM) // R1 R2
            || ((i_req_cmd == FCD_CMD_SUSPEND || i_req_cmd == FCD_CMD_RESUME) && !erase_ff) // R12
            || (i_req_cmd == FCD_CMD_BUF_PROGRAM && i_req_count > 5'(BUF_WORDS - 1));
        case (state_ff)
            H_IDLE: begin
                if (i_req_valid && sup_s2_ff) begin // R5 R9
                    if (bad_req) begin
                        nxt_rej = 1'b1;
                    end else begin
                        nxt_cmd = i_req_cmd;
                        nxt_addr = i_req_addr;
                        nxt_data = i_req_data;
                        nxt_cnt = i_req_count;
                        nxt_step = '0;
                        nxt_state = H_ISSUE;
                    end
                end
            end
            H_ISSUE: begin
                bc_start = 1'b1;
                nxt_state = H_WAIT;
            end
            H_WAIT: begin
                if (bc_done) begin
                    if (!seq_wr) nxt_rdata = bc_rdata;
                    if (step_ff == seq_len - 5'h01 || step_ff == SEQ_MAX) begin
                        nxt_state = H_DONE;
                    end else begin
                        nxt_step = step_ff + 5'h01;
                        nxt_state = H_ISSUE;
                    end
                end
            end
            H_DONE: begin
                case (cmd_ff)
                    FCD_CMD_OTP_ENTER: nxt_otp = 1'b1; // R24
                    FCD_CMD_OTP_EXIT, FCD_CMD_RESET: nxt_otp = 1'b0; // R4
                    FCD_CMD_SECTOR_ERASE: nxt_erase = 1'b1;
                    FCD_CMD_CHIP_ERASE: nxt_erase = 1'b0;
                    default: nxt_erase = erase_ff;
                endcase
                nxt_state = H_IDLE;
            end
            default: nxt_state = H_IDLE;
        endcase
        // Supply loss: flash resets, so host drops its mode knowledge
        if (!sup_s2_ff) begin // R5
            nxt_otp = 1'b0;
            nxt_erase = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= H_IDLE;
            cmd_ff <= FCD_CMD_RESET;
            addr_ff <= '0;
            data_ff <= '0;
            cnt_ff <= '0;
            step_ff <= '0;
            otp_ff <= 1'b0;
            erase_ff <= 1'b0;
            rej_ff <= 1'b0;
            rdata_ff <= '0;
        end else if (i_clk_en) begin
            state_ff <= nxt_state;
            cmd_ff <= nxt_cmd;
            addr_ff <= nxt_addr;
            data_ff <= nxt_data;
            cnt_ff <= nxt_cnt;
            step_ff <= nxt_step;
            otp_ff <= nxt_otp;
            erase_ff <= nxt_erase;
            rej_ff <= nxt_rej;
            rdata_ff <= nxt_rdata;
        end
    end

    // Erasing flag is a host-side guess; a busy poll would refine it
    fcd_bus_cycle u_cycle (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_ce(i_clk_en),
        .i_start(bc_start),
        .i_write(seq_wr),
        .i_addr(seq_addr),
        .i_wdata(seq_data),
        .o_done(bc_done),
        .o_rdata(bc_rdata),
        .o_addr(o_flash_addr),
        .o_dq_out(o_flash_dq_out),
        .o_dq_oe(o_flash_dq_oe),
        .i_dq_sync(dq_s2_ff),
        .o_cs_n(o_flash_cs_n),
        .o_we_n(o_flash_we_n),
        .o_oe_n(o_flash_oe_n)
    );

    assign o_req_ready = state_ff == H_IDLE && sup_s2_ff;
    assign o_done = state_ff == H_DONE;
    assign o_rejected = rej_ff;
    assign o_rdata = rdata_ff;
    assign o_otp_mode = otp_ff;
    assign o_erasing = erase_ff;

    sequence unlock_first_s;
        state_ff == H_ISSUE && step_ff == 5'h00 && cmd_ff != FCD_CMD_RESET && cmd_ff != FCD_CMD_READ
            && cmd_ff != FCD_CMD_SUSPEND && cmd_ff != FCD_CMD_RESUME;
    endsequence
    unlock_addr_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        unlock_first_s |-> seq_addr == UNLOCK_ADDR1 && seq_data == D_UNLOCK1) // R13
        else $error("first unlock write wrong");
    no_write_low_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        !sup_s2_ff && state_ff == H_IDLE |=> state_ff == H_IDLE) // R5
        else $error("request taken with supply low");
    suspend_gate_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        state_ff == H_ISSUE && cmd_ff == FCD_CMD_SUSPEND |-> erase_ff) // R12
        else $error("suspend outside sector erase");
    otp_track_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        state_ff == H_DONE && cmd_ff == FCD_CMD_OTP_ENTER && sup_s2_ff && i_clk_en |=> otp_ff) // R16
        else $error("region mode not tracked");
    reset_code_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        state_ff == H_ISSUE && cmd_ff == FCD_CMD_RESET |-> seq_data == D_RESET) // R14
        else $error("reset code wrong");
    buf_count_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        cmd_ff == FCD_CMD_BUF_PROGRAM && step_ff == 5'h03 && !o_flash_we_n |-> o_flash_dq_out == {11'h000, cnt_ff}) // R22
        else $error("load count wrong");
    factory_lock_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        state_ff == H_ISSUE && cmd_ff == FCD_CMD_PROGRAM |-> !(otp_ff && i_otp_factory_locked)) // R1
        else $error("program into locked region");
endmodule

// [test/fcd_flash_model.sv]
/* Flash model: decodes write cycles and answers reads.
 * Assumes the bench resolves the shared data wire. */
module fcd_flash_model
    import fcd_pkg::*;
#(
    parameter logic [15:0] MANUF = 16'h005a // Arbitrary maker code
) (
    // Flash pins
    input wire logic [21:0] i_addr,
    input wire logic [15:0] i_dq,
    input wire logic i_cs_n,
    input wire logic i_we_n,
    input wire logic i_oe_n,
    output logic [15:0] o_dq,
    output logic o_wr = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [logic [21:0]];
    logic [21:0] la;
    logic [2:0] st = 3'h0;
    logic idm = 1'b0;
    // Far start time: the strobe leaving unknown at reset is no write
    realtime t0 = 1.0e9;
    wire logic stb = i_cs_n | i_we_n;
    function automatic logic [15:0] rd(input logic [21:0] a);
        if (idm)
            return (a[7:0] == 8'h00) ? MANUF : {15'h0, a[12]};
        return mem.exists(a) ? mem[a] : 16'hffff;
    endfunction
    // Released wire shows the inverse, so a late sample never matches
    assign o_dq = (!i_cs_n && !i_oe_n) ? rd(i_addr) : ~rd(i_addr);
    always @(negedge stb) begin
        la = i_addr;
        t0 = $realtime;
    end
    always @(posedge stb) if (i_oe_n && $realtime - t0 >= 5.0) begin
        o_wr = 1'b1;
        o_wr <= #1 1'b0;
        if (st == 3'h3) mem[la] = i_dq;
        if (st == 3'h2) idm = (i_dq == D_IDENT);
        if (i_dq == D_RESET || (st == 3'h4 && i_dq == D_OTP_EXIT)) idm = 1'b0;
        if (st == 3'h2)
            st = (i_dq == D_PROGRAM) ? 3'h3 : (i_dq == D_IDENT) ? 3'h4 : 3'h0;
        else
            st = {1'b0, st == 3'h1 && la == UNLOCK_ADDR2 && i_dq == D_UNLOCK2,
                  st != 3'h1 && la == UNLOCK_ADDR1 && i_dq == D_UNLOCK1};
    end
endmodule

// [test/testbench.sv]
/* Bench for fcd_host against the flash model.
 * Assumes one 25 MHz clock; expected writes are queued and matched. */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import fcd_pkg::*;
    localparam logic [15:0] MANUF = 16'h005a; // Arbitrary maker code
    logic i_clk = 1'b0, i_reset_n = 1'b0, i_clk_en = 1'b1, i_req_valid = 1'b0, i_supply_ok = 1'b1;
    logic i_otp_factory_locked = 1'b0, o_req_ready, o_done, o_rejected, o_otp_mode, o_erasing;
    logic o_flash_dq_oe, o_flash_cs_n, o_flash_we_n, o_flash_oe_n, wr;
    fcd_cmd_t i_req_cmd = FCD_CMD_RESET;
    logic [21:0] i_req_addr = 22'h0, o_flash_addr, a;
    logic [15:0] i_req_data = 16'h0, o_rdata, o_flash_dq_out, m_dq, i_buf_data [BUF_WORDS];
    logic [4:0] i_req_count = 5'h0, n;
    logic [31:0] seed = 32'd72, r;
    int error_cnt = 0, check_count = 0;
    logic [37:0] wq [$];
    logic [15:0] rq [$];
    wire logic [15:0] i_flash_dq_in = o_flash_dq_oe ? o_flash_dq_out : m_dq;
    fcd_host dut (.*);
    fcd_flash_model #(.MANUF(MANUF)) flash (.i_addr(o_flash_addr), .i_dq(i_flash_dq_in), .i_cs_n(o_flash_cs_n),
        .i_we_n(o_flash_we_n), .i_oe_n(o_flash_oe_n), .o_dq(m_dq), .o_wr(wr));
    initial forever #20 i_clk = ~i_clk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic void pw(input logic [21:0] ad, input logic [15:0] d);
        wq.push_back({ad, d});
    endfunction
    function automatic void pre(input logic [15:0] code, input logic [21:0] ad);
        pw(UNLOCK_ADDR1, D_UNLOCK1);
        pw(UNLOCK_ADDR2, D_UNLOCK2);
        pw(ad, code);
    endfunction
    task automatic chk(input logic [37:0] got, input logic [37:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input fcd_cmd_t c, input logic [21:0] ad, input logic [15:0] d = 16'h0,
                       input logic [4:0] cnt = 5'h0, input logic rej = 1'b0);
        wait (o_req_ready === 1'b1);
        @(posedge i_clk);
        i_req_valid <= 1'b1;
        i_req_cmd <= c;
        i_req_addr <= ad;
        i_req_data <= d;
        i_req_count <= cnt;
        @(posedge i_clk);
        i_req_valid <= 1'b0;
        wait (o_done === 1'b1 || o_rejected === 1'b1);
        #1 chk(o_rejected, rej);
        @(posedge i_clk);
    endtask
    task automatic tally_and_finish();
        if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // A write with no note queued is compared against its own inverse
    always @(posedge wr) chk({o_flash_addr, i_flash_dq_in}, wq.size() != 0 ? wq.pop_front() : ~{o_flash_addr,
        i_flash_dq_in});
    always @(negedge i_clk) if (o_done === 1'b1 && rq.size() != 0) chk(o_rdata, rq.pop_front());
    initial begin
        for (int i = 0; i < BUF_WORDS; i++)
            i_buf_data[i] = 16'h0;
        repeat (20) @(posedge i_clk);
        i_reset_n <= 1'b1;
        pw(ANY_ADDR, D_RESET);
        cmd(FCD_CMD_RESET, ANY_ADDR);
        r = xs();
        a = r[21:0];
        pre(D_PROGRAM, UNLOCK_ADDR1);
        pw(a, r[31:16]);
        cmd(FCD_CMD_PROGRAM, a, r[31:16]);
        rq.push_back(r[31:16]);
        cmd(FCD_CMD_READ, a);
        for (int k = 0; k < 2; k++) begin
            pre(D_IDENT, UNLOCK_ADDR1);
            rq.push_back(k ? 16'h0001 : MANUF);
            cmd(FCD_CMD_IDENT, k ? 22'h001002 : OFS_MANUF);
        end
        for (int k = 0; k < 2; k++) begin
            pre(D_ERASE_SETUP, UNLOCK_ADDR1);
            pre(k ? D_SECTOR_ERASE : D_CHIP_ERASE, k ? (a & SECTOR_MASK) : UNLOCK_ADDR1);
            cmd(k ? FCD_CMD_SECTOR_ERASE : FCD_CMD_CHIP_ERASE, a);
            if (k == 0) cmd(FCD_CMD_SUSPEND, ANY_ADDR, 16'h0, 5'h0, 1'b1);
        end
        #1 chk(o_erasing, 1'b1);
        pw(ANY_ADDR, D_SUSPEND);
        cmd(FCD_CMD_SUSPEND, ANY_ADDR);
        pw(ANY_ADDR, D_RESUME);
        cmd(FCD_CMD_RESUME, ANY_ADDR);
        pre(D_OTP_ENTER, UNLOCK_ADDR1);
        cmd(FCD_CMD_OTP_ENTER, ANY_ADDR);
        #1 chk(o_otp_mode, 1'b1);
        i_otp_factory_locked <= 1'b1;
        cmd(FCD_CMD_PROGRAM, a, 16'h0, 5'h0, 1'b1);
        i_otp_factory_locked <= 1'b0;
        pre(D_PROGRAM, UNLOCK_ADDR1);
        pw(a, 16'h0);
        cmd(FCD_CMD_PROGRAM, a);
        pre(D_IDENT, UNLOCK_ADDR1);
        pw(ANY_ADDR, D_OTP_EXIT);
        cmd(FCD_CMD_OTP_EXIT, ANY_ADDR);
        #1 chk(o_otp_mode, 1'b0);
        r = xs();
        a = r[21:0] & 22'h3ffff0;
        n = {1'b0, r[25:22]};
        pre(D_BUF_LOAD, a & SECTOR_MASK);
        pw(a & SECTOR_MASK, {11'h0, n});
        for (int i = 0; i < BUF_WORDS; i++) begin
            r = xs();
            i_buf_data[i] <= r[15:0];
            if (i <= n) pw(a + 22'(i), r[15:0]);
        end
        pw(a & SECTOR_MASK, D_BUF_CONFIRM);
        cmd(FCD_CMD_BUF_PROGRAM, a, 16'h0, n);
        cmd(FCD_CMD_BUF_PROGRAM, a, 16'h0, 5'h10, 1'b1);
        pre(D_RESET, UNLOCK_ADDR1);
        cmd(FCD_CMD_BUF_ABORT, ANY_ADDR);
        i_supply_ok <= 1'b0;
        repeat (4) @(posedge i_clk);
        #1 chk(o_req_ready, 1'b0);
        @(posedge i_clk);
        i_supply_ok <= 1'b1;
        chk(38'(wq.size()), 38'h0);
        tally_and_finish();
    end
    initial begin
        #400us;
        error_cnt++;
        tally_and_finish();
    end
endmodule
